// File: design/dbg_freeze_regs.svh
/*
  register map, field positions and reset values of the debug freeze
  control bank. assumes a 32-bit apb bus with byte addresses.
*/
`ifndef DBG_FREEZE_REGS_SVH
`define DBG_FREEZE_REGS_SVH

// byte address of the freeze control register
`define FRZ_CTRL_ADDR      32'hE004_2000
// byte address of the read-only freeze status register
`define FRZ_STAT_ADDR      32'hE004_2004

// freeze control register fields
`define FRZ_WDT_BIT        0
`define FRZ_ASYNC_TMR_BIT  1
`define FRZ_EVT_SYS_BIT    2
`define FRZ_CTRL_WIDTH     3
`define FRZ_CTRL_RESET     3'h0
`define FRZ_CTRL_MASK      32'h0000_0007

// freeze status register fields (bits 2:0 mirror the freeze outputs)
`define FRZ_STAT_HALT_BIT  3
`define FRZ_STAT_WIDTH     4

// read data shown for reserved bits and unmapped addresses
`define FRZ_READ_ZERO      32'h0000_0000

`endif

// File: design/dbg_freeze_pkg.sv
/*
  types shared by the debug freeze control bank.
  assumes dbg_freeze_regs.svh supplies the field widths.
*/
`include "dbg_freeze_regs.svh"

package dbg_freeze_pkg;

  // one apb request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } apb_req_type;

  // per-peripheral freeze qualifiers
  typedef struct packed {
    logic evt_sys;
    logic async_tmr;
    logic wdt;
  } freeze_type;

endpackage : dbg_freeze_pkg

// File: design/dbg_freeze_ctrl.sv
/*
  debug freeze control bank: one software control register whose bits,
  qualified by the core-halted indication, freeze the watchdog, the
  asynchronous timer and the peripheral event system.
  assumes an apb master on MCLK_IN and a core-halted level that is
  already synchronous to MCLK_IN. the slave never inserts wait states,
  so a master that samples ready in the first access cycle completes
  every transfer there; unmapped addresses answer with an error.
*/
// Overview of operation
// - control register at E0042000, resets to zero
// - bit0 plus halt freezes watchdog counter
// - bit1 plus halt freezes async timer
// - bit2 plus halt freezes event system
// - cleared bit keeps peripheral running while halted
`timescale 1ns/100ps
`default_nettype none
`include "dbg_freeze_regs.svh"

module dbg_freeze_ctrl
  import dbg_freeze_pkg::*;
(
  // clock and reset
  input  wire  logic        MCLK_IN,
  input  wire  logic        RST_N_IN,
  // apb slave request
  input  wire  logic        PSEL_IN,
  input  wire  logic        PENABLE_IN,
  input  wire  logic        PWRITE_IN,
  input  wire  logic [31:0] PADDR_IN,
  input  wire  logic [31:0] PWDATA_IN,
  input  wire  logic [3:0]  PSTRB_IN,
  // apb slave answer
  output var   logic        PREADY_OUT,
  output var   logic [31:0] PRDATA_OUT,
  output var   logic        PSLVERR_OUT,
  // core debug state
  input  wire  logic        CORE_HALTED_IN,
  // freeze qualifiers to the peripherals
  output var   logic        WDT_FREEZE_OUT,
  output var   logic        ASYNC_TMR_FREEZE_OUT,
  output var   logic        EVT_SYS_FREEZE_OUT
);

  // internal state: the three control bits and the registered freeze
  // qualifiers; nothing else is remembered between transfers
  // bundled apb request
  apb_req_type                       req;
  // freeze control register
  logic [`FRZ_CTRL_WIDTH-1:0]        ctrl;
  // registered freeze qualifiers
  freeze_type                        frz;
  // next freeze qualifiers
  freeze_type                        next_frz;
  // next answer values and next control value
  logic                              next_pready;
  logic [31:0]                       next_prdata;
  logic                              next_pslverr;
  logic [`FRZ_CTRL_WIDTH-1:0]        next_ctrl;

  // decode wires
  wire logic setup_phase;             // first cycle of a transfer
  wire logic access_done;             // edge at which the transfer completes
  wire logic hit_ctrl;                // address selects the control register
  wire logic hit_stat;                // address selects the status register
  wire logic hit_any;                 // any mapped address
  wire logic ctrl_wr;                 // committed write to control register
  wire logic [31:0] ctrl_rd;          // control register as read data
  wire logic [31:0] stat_rd;          // status register as read data
  wire logic bus_ctrl_write;          // control write seen on the pins, for checks

  // pack the bus pins into one request
  assign req = '{sel: PSEL_IN, enable: PENABLE_IN, write: PWRITE_IN,
                 addr: PADDR_IN, wdata: PWDATA_IN, strb: PSTRB_IN};

  // transfer phases
  assign setup_phase = req.sel & ~req.enable;
  assign access_done = req.sel & req.enable & PREADY_OUT;

  // full-address decode: aliases of the register would let stray
  // writes elsewhere freeze a peripheral by accident
  // every other address answers with an error
  assign hit_ctrl = (req.addr == `FRZ_CTRL_ADDR);
  assign hit_stat = (req.addr == `FRZ_STAT_ADDR);
  assign hit_any  = hit_ctrl | hit_stat;

  // only lane 0 carries writable bits; upper lanes are reserved
  // a write with lane 0 off is dropped without an error
  assign ctrl_wr = access_done & req.write & hit_ctrl & req.strb[0];

  // reserved bits above the fields read as zero
  assign ctrl_rd = {29'h0000_0000, ctrl};
  assign stat_rd = {28'h000_0000, CORE_HALTED_IN, frz.evt_sys,
                    frz.async_tmr, frz.wdt};

  // next control value: only the three field bits are stored
  assign next_ctrl = ctrl_wr ? req.wdata[`FRZ_CTRL_WIDTH-1:0] : ctrl;

  // answer prepared in setup so that access completes without wait
  assign next_pready  = setup_phase;
  assign next_pslverr = setup_phase & ~hit_any;
  assign next_prdata  = (setup_phase & ~req.write & hit_ctrl) ? ctrl_rd :
                        (setup_phase & ~req.write & hit_stat) ? stat_rd :
                        `FRZ_READ_ZERO;

  // the halt level is used as is: it must already be on MCLK_IN,
  // a level from another clock needs a synchroniser outside
  // freeze only when the core is halted and the bit is set
  assign next_frz.wdt       = CORE_HALTED_IN & ctrl[`FRZ_WDT_BIT];
  assign next_frz.async_tmr = CORE_HALTED_IN & ctrl[`FRZ_ASYNC_TMR_BIT];
  assign next_frz.evt_sys   = CORE_HALTED_IN & ctrl[`FRZ_EVT_SYS_BIT];

  // control register, cleared by reset
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl <= `FRZ_CTRL_RESET;
    end else begin
      // hold, or take the field bits of a committed write
      ctrl <= next_ctrl;
    end
  end

  // registering the answer keeps every bus output glitch free;
  // the price is that the answer must be prepared during setup
  // apb answer flops
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= `FRZ_READ_ZERO;
    end else begin
      // answer pulse follows every setup cycle
      PREADY_OUT  <= next_pready;
      PSLVERR_OUT <= next_pslverr;
      PRDATA_OUT  <= next_prdata;
    end
  end

  // one cycle of latency from halt, two from the access cycle of a register write;
  // peripherals see at most one extra tick after the halt
  // freeze qualifier flops
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      frz <= '0;
    end else begin
      // follow halt and control bits one cycle later
      frz <= next_frz;
    end
  end

  // drive the peripheral qualifiers straight from the flops
  assign WDT_FREEZE_OUT       = frz.wdt;
  assign ASYNC_TMR_FREEZE_OUT = frz.async_tmr;
  assign EVT_SYS_FREEZE_OUT   = frz.evt_sys;

  // assertions guarding the bank

  // all checks run on MCLK_IN and, except the reset check, rest while reset is low
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  // reset holds the control register at zero, no peripheral frozen
  AST_CTRL_RESET_ZERO: assert property (
    disable iff (1'b0)
    (!RST_N_IN ##1 !RST_N_IN) |-> (ctrl == `FRZ_CTRL_RESET) && !WDT_FREEZE_OUT &&
                  !ASYNC_TMR_FREEZE_OUT && !EVT_SYS_FREEZE_OUT)
    else $error("control register or freeze outputs not zero in reset");

  // a committed write lands in the register and reads back
  AST_CTRL_WRITE_READBACK: assert property (
    ctrl_wr |=> (ctrl == $past(req.wdata[2:0])))
    else $error("control register did not take written value");

  // a read of the control register returns its value in access
  AST_CTRL_READ_DATA: assert property (
    (setup_phase && !req.write && hit_ctrl) |=>
      (PREADY_OUT && (PRDATA_OUT == {29'h0000_0000, $past(ctrl)})))
    else $error("control register read data wrong");

  // watchdog freeze follows halt and its bit one cycle later
  AST_WDT_FREEZE: assert property (
    (CORE_HALTED_IN && ctrl[0]) ##1 (CORE_HALTED_IN && ctrl[0])
      |-> WDT_FREEZE_OUT)
    else $error("watchdog not frozen while halted with bit set");

  // timer freeze follows halt and its bit one cycle later
  AST_TMR_FREEZE: assert property (
    (CORE_HALTED_IN && ctrl[1]) |=> ASYNC_TMR_FREEZE_OUT)
    else $error("async timer not frozen while halted with bit set");

  // event system freeze follows halt and its bit one cycle later
  AST_EVT_FREEZE: assert property (
    (CORE_HALTED_IN && ctrl[2]) |=> EVT_SYS_FREEZE_OUT)
    else $error("event system not frozen while halted with bit set");

  // a cleared bit never freezes its peripheral
  AST_CLEAR_RUNS: assert property (
    ($past(!ctrl[0]) |-> !WDT_FREEZE_OUT) and
    ($past(!ctrl[1]) |-> !ASYNC_TMR_FREEZE_OUT) and
    ($past(!ctrl[2]) |-> !EVT_SYS_FREEZE_OUT))
    else $error("peripheral frozen with its bit cleared");

  // no freeze from the second cycle that the core runs
  AST_RUN_NO_FREEZE: assert property (
    !CORE_HALTED_IN [*2] |-> !(WDT_FREEZE_OUT || ASYNC_TMR_FREEZE_OUT ||
                               EVT_SYS_FREEZE_OUT))
    else $error("peripheral frozen while core running");

  // reserved bits read as zero on every answer
  AST_RESERVED_ZERO: assert property (
    PREADY_OUT |-> (PRDATA_OUT[31:4] == 28'h000_0000) &&
                   (!$past(hit_stat) -> PRDATA_OUT[3] == 1'b0))
    else $error("reserved read data bits not zero");

  // reserved control bits never read back, whatever was written
  AST_RESERVED_WRITE: assert property (
    (setup_phase && !req.write && hit_ctrl) |=>
      (PRDATA_OUT[31:3] == 29'h0000_0000))
    else $error("reserved bits stored a written value");

  // unmapped access answers with an error and zero data
  AST_UNMAPPED_ERROR: assert property (
    (setup_phase && !hit_any) |=>
      (PREADY_OUT && PSLVERR_OUT && (PRDATA_OUT == `FRZ_READ_ZERO)))
    else $error("unmapped access not flagged");

  // ready comes one cycle after every setup
  AST_READY_AFTER_SETUP: assert property (
    setup_phase |=> PREADY_OUT)
    else $error("ready missing after setup");

  // ready never comes without a setup before it
  AST_READY_NEEDS_SETUP: assert property (
    PREADY_OUT |-> $past(setup_phase))
    else $error("ready without setup");

  // ready stands for one cycle only
  AST_READY_ONE_CYCLE: assert property (
    PREADY_OUT |=> !PREADY_OUT)
    else $error("ready stood longer than one cycle");

  // mapped addresses never answer with an error
  AST_MAPPED_NO_ERROR: assert property (
    (setup_phase && hit_any) |=> !PSLVERR_OUT)
    else $error("error on a mapped address");

  // an error only comes together with ready
  AST_ERROR_NEEDS_READY: assert property (
    PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");

  // outside an answer the data and error lines rest at zero
  AST_IDLE_ANSWER_ZERO: assert property (
    !PREADY_OUT |-> (PRDATA_OUT == `FRZ_READ_ZERO) &&
                    !PSLVERR_OUT)
    else $error("answer lines not idle");

  // status read shows halt and the three freeze outputs
  AST_STATUS_READ_DATA: assert property (
    (setup_phase && !req.write && hit_stat) |=>
      (PRDATA_OUT == {28'h000_0000, $past(CORE_HALTED_IN), $past(EVT_SYS_FREEZE_OUT),
                      $past(ASYNC_TMR_FREEZE_OUT), $past(WDT_FREEZE_OUT)}))
    else $error("status read data wrong");

  // control write decoded straight from the pins
  assign bus_ctrl_write = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN &
                          PSTRB_IN[0] & (PADDR_IN == `FRZ_CTRL_ADDR);

  // without a control write the register keeps its value
  AST_NO_WRITE_HOLDS: assert property (
    !bus_ctrl_write |=> $stable(ctrl))
    else $error("control register changed without a write");

  // a control write seen on the pins lands in the field bits
  AST_PIN_WRITE_LANDS: assert property (
    bus_ctrl_write |=> (ctrl == $past(PWDATA_IN[2:0])))
    else $error("pin level write did not land");

  // a running core releases every freeze one cycle later
  AST_FREEZE_RELEASE: assert property (
    !CORE_HALTED_IN |=>
      !(WDT_FREEZE_OUT || ASYNC_TMR_FREEZE_OUT || EVT_SYS_FREEZE_OUT))
    else $error("freeze held after the core resumed");

  // main scenarios
  // watchdog frozen after a register write
  COV_WDT_FROZEN: cover property (
    ctrl_wr ##[1:20] WDT_FREEZE_OUT);
  // every peripheral frozen at once
  COV_ALL_FROZEN: cover property (
    WDT_FREEZE_OUT && ASYNC_TMR_FREEZE_OUT && EVT_SYS_FREEZE_OUT);
  // halted with no bit set, nothing frozen
  COV_HALT_NO_FREEZE: cover property (
    CORE_HALTED_IN [*3] ##0 (ctrl == 3'h0));
  // status read while halted
  COV_STATUS_READ: cover property (
    setup_phase && !req.write && hit_stat ##1 PRDATA_OUT[3]);
  // write that sets reserved bits
  COV_RESERVED_WRITE: cover property (
    ctrl_wr && (req.wdata[31:3] != 29'h0000_0000));

endmodule // dbg_freeze_ctrl

`default_nettype wire

// File: verif/frz_periph_model.sv
/*
  stand-ins for the freezable peripherals: three free-running counters.
  assumes freeze levels synchronous to clk_in.
*/
`timescale 1ns/100ps
`default_nettype none

module frz_periph_model
  import dbg_freeze_pkg::*;
(
  // clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  // freeze qualifiers
  input  wire freeze_type      frz_in,
  // counter values: watchdog, timer, event system
  output var  logic [2:0][7:0] cnt_out
);
  // each counter holds while its freeze is high, else advances
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_out <= '0;
    end else begin
      cnt_out[0] <= frz_in.wdt ? cnt_out[0] : cnt_out[0] + 8'h01;
      cnt_out[1] <= frz_in.async_tmr ? cnt_out[1] : cnt_out[1] + 8'h01;
      cnt_out[2] <= frz_in.evt_sys ? cnt_out[2] : cnt_out[2] + 8'h01;
    end
  end
endmodule // frz_periph_model

`default_nettype wire

// File: verif/debug_freeze_control_test.sv
/*
  self-checking bench: apb register access and freeze qualifiers.
  assumes a zero-wait apb slave and a halt level in the mclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dbg_freeze_regs.svh"

module debug_freeze_control_test;
  import dbg_freeze_pkg::*;
  logic            mclk = 1'h0;   // system clock
  logic            rst_n = 1'h0;  // async reset
  apb_req_type     req = '0;      // apb request
  logic            halted = 1'h0; // core halted level
  logic            pready, pslverr, wdt_f, tmr_f, evt_f;
  logic [31:0]     prdata;        // read data
  logic [2:0][7:0] cnt;           // peripheral counters
  freeze_type      frz;           // freeze bundle to the model
  int              error_cnt = 0;
  int              n_compared = 0;
  logic [31:0]     seed = 32'h0001_3024;

  assign frz = {evt_f, tmr_f, wdt_f};
  // clock at 200 MHz
  always #2.5 mclk = ~mclk;

  dbg_freeze_ctrl dut_u (.MCLK_IN(mclk), .RST_N_IN(rst_n), .PSEL_IN(req.sel),
    .PENABLE_IN(req.enable), .PWRITE_IN(req.write), .PADDR_IN(req.addr),
    .PWDATA_IN(req.wdata), .PSTRB_IN(req.strb), .PREADY_OUT(pready),
    .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .CORE_HALTED_IN(halted),
    .WDT_FREEZE_OUT(wdt_f), .ASYNC_TMR_FREEZE_OUT(tmr_f), .EVT_SYS_FREEZE_OUT(evt_f));
  frz_periph_model periph_u (.clk_in(mclk), .rst_n_in(rst_n), .frz_in(frz), .cnt_out(cnt));

  // xorshift step for random data
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // expected freeze outputs for a control value and halt level
  function automatic logic [2:0] exp_frz(input logic [2:0] c, input logic h);
    return h ? c : 3'h0;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer: setup, access until pready
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{sel: 1'h1, enable: 1'h0, write: wr, addr: a, wdata: d, strb: s};
    @(posedge mclk);
    req.enable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    req <= '0;
    check("wait states", 32'(n), 32'h1);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] rd, v;
    logic        er;
    logic [2:0]  e;
    logic [2:0][7:0] c0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    apb(1'h0, `FRZ_CTRL_ADDR, 32'h0, 4'hF, rd, er);
    check("ctrl reset", rd, 32'h0);
    $display("reset test done");
    // random writes with readback, one idle cycle between transfers
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      apb(1'h1, `FRZ_CTRL_ADDR, seed, 4'hF, rd, er);
      apb(1'h0, `FRZ_CTRL_ADDR, 32'h0, 4'hF, rd, er);
      check("ctrl readback", rd, seed & 32'h7);
      check("ctrl err", {31'h0, er}, 32'h0);
    end
    // lane 0 off or status target: write dropped; unmapped place errors
    v = seed & 32'h7;
    apb(1'h1, `FRZ_CTRL_ADDR, ~v, 4'hE, rd, er);
    apb(1'h0, `FRZ_CTRL_ADDR, 32'h0, 4'hF, rd, er);
    check("strobe off", rd, v);
    apb(1'h1, `FRZ_STAT_ADDR, 32'hFFFF_FFFF, 4'hF, rd, er);
    check("status write err", {31'h0, er}, 32'h0);
    apb(1'h0, `FRZ_CTRL_ADDR, 32'h0, 4'hF, rd, er);
    check("status write ignored", rd, v);
    apb(1'h0, 32'hE004_2008, 32'h0, 4'hF, rd, er);
    check("unmapped err", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("register test done");
    // every control value, halted and running
    for (int i = 0; i < 16; i++) begin
      apb(1'h1, `FRZ_CTRL_ADDR, 32'(i) | 32'hFFFF_FFF0, 4'hF, rd, er);
      halted <= i[3];
      repeat (3) @(posedge mclk);
      e = exp_frz(i[2:0], i[3]);
      check("freeze", {29'h0, evt_f, tmr_f, wdt_f}, {29'h0, e});
      c0 = cnt;
      repeat (4) @(posedge mclk);
      for (int k = 0; k < 3; k++) begin
        check("counter step", {24'h0, 8'(cnt[k] - c0[k])}, e[k] ? 32'h0 : 32'h4);
      end
      apb(1'h0, `FRZ_STAT_ADDR, 32'h0, 4'hF, rd, er);
      check("status", rd, {28'h0, i[3], e});
    end
    $display("freeze test done");
    // reset in mid-run while halted and frozen
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    check("freeze in reset", {29'h0, evt_f, tmr_f, wdt_f}, 32'h0);
    rst_n <= 1'h1;
    apb(1'h0, `FRZ_CTRL_ADDR, 32'h0, 4'hF, rd, er);
    check("ctrl after reset", rd, 32'h0);
    $display("second reset test done");
    give_verdict();
  end

  // watchdog against a hung bus
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    give_verdict();
  end
endmodule // debug_freeze_control_test

`default_nettype wire
